// ==== include/mmix_pkg.sv ====
package mmix_pkg;
   // channel and sample geometry
   localparam int NCH      = 4;
   localparam int SW       = 24;
   localparam int GW       = 16;
   localparam int PW       = 9;
   localparam int CHW      = 2;
   localparam int FRAME_W  = NCH * SW;

   // fader gain, unsigned q4.12; unity is 0 dB, ceiling is +12 dB
   localparam logic [GW-1:0] GAIN_UNITY  = 16'h1000;
   localparam logic [GW-1:0] GAIN_MAX    = 16'h3FB2;
   localparam logic [GW-1:0] SEND_RESET  = 16'h0000;
   localparam int            GAIN_FRAC   = 12;

   // pan position, 0 hard left .. 0x100 hard right
   localparam logic [PW-1:0] PAN_LEFT    = 9'h000;
   localparam logic [PW-1:0] PAN_CENTER  = 9'h080;
   localparam logic [PW-1:0] PAN_RIGHT   = 9'h100;
   localparam int            PAN_FRAC    = 8;

   // full scale limits of a sample, in accumulator width
   localparam logic signed [31:0] FS_MAX = 32'sh007F_FFFF;
   localparam logic signed [31:0] FS_MIN = -32'sh0080_0000;

   // send buses and jack types
   localparam int            NBUS        = 3;
   localparam logic [1:0]    BUS_AUX1    = 2'h0;
   localparam logic [1:0]    BUS_AUX2    = 2'h1;
   localparam logic [1:0]    BUS_HP      = 2'h2;
   localparam logic [1:0]    JACK_MIC    = 2'h0;
   localparam logic [1:0]    JACK_LINE   = 2'h1;
   localparam logic [1:0]    JACK_HIZ    = 2'h2;

   // aux path structure and timing, input fifo depth, meter hold width
   localparam int            AUX_INSERT_SLOTS = 4;
   localparam int            AUX_DELAY        = 32;
   localparam logic [5:0]    AUX_DELAY_CNT    = 6'h20;
   localparam int            FIFO_DEPTH       = 8;
   localparam int            HOLD_W           = 16;
endpackage

// ==== verilog/mmix_fifo.sv ====
`timescale 1ns/1ps
module mmix_fifo #(
   parameter int W = 96,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0]  wp_q;
   logic [AW:0]  rp_q;
   wire          full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire          empty = (wp_q == rp_q);
   wire          push  = in_valid && !full;
   wire          pop   = out_valid && out_ready;

   // handshake flags straight from the pointers
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rp_q[AW-1:0]];

   // storage write, no reset needed
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wp_q[AW-1:0]] <= in_data;
      end
   end

   // pointers with wrap bit
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop)  rp_q <= rp_q + 1'b1;
      end
   end

   fifo_no_over_a : assert property (@(posedge clock) disable iff (!rst_n)
      full |=> (wp_q == $past(wp_q)))
      else $error("fifo written while full");
endmodule // mmix_fifo

// ==== verilog/mmix_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// - fader scales monitor, post aux and post fader meter
// - fader gain capped at plus twelve dB
// - zero dB fader passes samples unchanged
// - copy mix loads faders, pans into bus
// - meter taps pre or post fader
// - clip flag when level exceeds full scale
// - peak and clip hold times programmable
// - every channel always processed, hidden or not
// - only channels one and two link; mirrored
// - link refused unless same jack, not instrument
// - link copies left settings except pan
// - linked send pans forced hard left/right
// - unlink keeps first centred, second defaulted
// - two stereo aux buses, four insert slots
// - post aux follows fader, mute; pre ignores
// - second aux silent at two top rates
// - aux outputs lag monitor by 32 samples
// - mute drops monitor and post aux, not cue
// - solo silences others on monitor, beats mute there
module mmix_core (
   // clock and reset
   input  wire logic                                clock,
   input  wire logic                                rst_n,
   // input sample frames, one word per channel
   input  wire logic                                in_valid,
   output logic                                     in_ready,
   input  wire logic [mmix_pkg::FRAME_W-1:0]        in_frame,
   // channel strip writes
   input  wire logic                                ctl_wr,
   input  wire logic [mmix_pkg::CHW-1:0]            ctl_ch,
   input  wire logic [mmix_pkg::GW-1:0]             ctl_fader,
   input  wire logic [mmix_pkg::PW-1:0]             ctl_pan,
   input  wire logic                                ctl_mute,
   input  wire logic                                ctl_solo,
   // send writes and copy mix
   input  wire logic                                snd_wr,
   input  wire logic [1:0]                          snd_bus,
   input  wire logic [mmix_pkg::CHW-1:0]            snd_ch,
   input  wire logic [mmix_pkg::GW-1:0]             snd_level,
   input  wire logic [mmix_pkg::PW-1:0]             snd_pan,
   input  wire logic                                mix_copy_req,
   input  wire logic [1:0]                          mix_copy_destination,
   // stereo link of channels one and two
   input  wire logic                                link_req,
   input  wire logic                                link_set,
   input  wire logic [2*mmix_pkg::NCH-1:0]          jack_type,
   output logic                                     linked,
   // global settings
   input  wire logic [1:0]                          aux_pre,
   input  wire logic                                rate_high,
   input  wire logic                                meter_post,
   input  wire logic [mmix_pkg::HOLD_W-1:0]         peak_hold_frames,
   input  wire logic [mmix_pkg::HOLD_W-1:0]         clip_hold_frames,
   // mixed outputs
   output logic                                     out_valid,
   input  wire logic                                out_ready,
   output logic [mmix_pkg::SW-1:0]                  mon_l,
   output logic [mmix_pkg::SW-1:0]                  mon_r,
   output logic [mmix_pkg::SW-1:0]                  aux1_l,
   output logic [mmix_pkg::SW-1:0]                  aux1_r,
   output logic [mmix_pkg::SW-1:0]                  aux2_l,
   output logic [mmix_pkg::SW-1:0]                  aux2_r,
   output logic [mmix_pkg::SW-1:0]                  headphone_cue_bus_l,
   output logic [mmix_pkg::SW-1:0]                  headphone_cue_bus_r,
   // meters
   output logic [mmix_pkg::FRAME_W-1:0]             meter_peak,
   output logic [mmix_pkg::NCH-1:0]                 clip
);
   localparam int NCH = mmix_pkg::NCH;
   localparam int SW  = mmix_pkg::SW;

   function automatic logic signed [31:0] mulg(input logic signed [31:0] x,
                                               input logic [mmix_pkg::GW-1:0] g);
      logic signed [48:0] p;
      p = x * $signed({1'b0, g});
      return p[mmix_pkg::GAIN_FRAC +: 32];
   endfunction

   function automatic logic signed [31:0] mulp(input logic signed [31:0] x,
                                               input logic [mmix_pkg::PW-1:0] w);
      logic signed [41:0] p;
      p = x * $signed({1'b0, w});
      return p[mmix_pkg::PAN_FRAC +: 32];
   endfunction

   function automatic logic [SW-1:0] sat(input logic signed [31:0] x);
      logic [SW-1:0] r;
      r = x[SW-1:0];
      if (x > mmix_pkg::FS_MAX) r = mmix_pkg::FS_MAX[SW-1:0];
      if (x < mmix_pkg::FS_MIN) r = mmix_pkg::FS_MIN[SW-1:0];
      return r;
   endfunction

   // control state
   logic [mmix_pkg::GW-1:0] fader_q    [NCH];
   logic [mmix_pkg::PW-1:0] pan_q      [NCH];
   logic [NCH-1:0]          mute_q;
   logic [NCH-1:0]          solo_q;
   logic [mmix_pkg::GW-1:0] send_lvl_q [mmix_pkg::NBUS][NCH];
   logic [mmix_pkg::PW-1:0] send_pan_q [mmix_pkg::NBUS][NCH];
   logic                    linked_q;
   logic                    out_valid_q;

   // fifo between source and mixer
   logic                    fifo_valid;
   logic [mmix_pkg::FRAME_W-1:0] fifo_data;
   wire                     take = !out_valid_q || out_ready;
   wire                     pop  = fifo_valid && take;

   mmix_fifo #(.W(mmix_pkg::FRAME_W), .D(mmix_pkg::FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   (in_frame),
      .out_valid (fifo_valid),
      .out_ready (take),
      .out_data  (fifo_data)
   );

   // write decode and link qualification
   wire            link_ok   = (jack_type[1:0] == jack_type[3:2]) &&
                               (jack_type[1:0] != mmix_pkg::JACK_HIZ);
   wire            do_link   = link_req && link_set && !linked_q && link_ok;
   wire            do_unlink = link_req && !link_set && linked_q;
   wire            ctl_pair  = linked_q && (ctl_ch[1] == 1'b0);
   wire            snd_pair  = linked_q && (snd_ch[1] == 1'b0);
   localparam int  CHW_M     = mmix_pkg::CHW - 1;
   wire [CHW_M:0]  ctl_mate  = {1'b0, ~ctl_ch[0]};
   wire [CHW_M:0]  snd_mate  = {1'b0, ~snd_ch[0]};
   wire [mmix_pkg::GW-1:0] fader_in = (ctl_fader > mmix_pkg::GAIN_MAX) ?
                                      mmix_pkg::GAIN_MAX : ctl_fader;
   wire [mmix_pkg::GW-1:0] level_in = (snd_level > mmix_pkg::GAIN_MAX) ?
                                      mmix_pkg::GAIN_MAX : snd_level;
   wire [mmix_pkg::PW-1:0] pan_in   = (ctl_pan > mmix_pkg::PAN_RIGHT) ?
                                      mmix_pkg::PAN_RIGHT : ctl_pan;
   wire [mmix_pkg::PW-1:0] span_in  = (snd_pan > mmix_pkg::PAN_RIGHT) ?
                                      mmix_pkg::PAN_RIGHT : snd_pan;
   wire            copy_ok   = mix_copy_req && (mix_copy_destination != 2'h3);

   assign linked = linked_q;

   // link state
   always_ff @(posedge clock) begin
      if (!rst_n)         linked_q <= 1'b0;
      else if (do_link)   linked_q <= 1'b1;
      else if (do_unlink) linked_q <= 1'b0;
   end

   // channel strip controls
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < NCH; i++) begin
            fader_q[i] <= mmix_pkg::GAIN_UNITY;
            pan_q[i]   <= mmix_pkg::PAN_CENTER;
         end
         mute_q <= '0;
         solo_q <= '0;
      end else if (do_link) begin
         fader_q[1] <= fader_q[0];
         mute_q[1]  <= mute_q[0];
         solo_q[1]  <= solo_q[0];
         pan_q[0]   <= mmix_pkg::PAN_LEFT;
         pan_q[1]   <= mmix_pkg::PAN_RIGHT;
      end else if (do_unlink) begin
         pan_q[0]   <= mmix_pkg::PAN_CENTER;
         pan_q[1]   <= mmix_pkg::PAN_CENTER;
         fader_q[1] <= mmix_pkg::GAIN_UNITY;
         mute_q[1]  <= 1'b0;
         solo_q[1]  <= 1'b0;
      end else if (ctl_wr) begin
         fader_q[ctl_ch] <= fader_in;
         pan_q[ctl_ch]   <= pan_in;
         mute_q[ctl_ch]  <= ctl_mute;
         solo_q[ctl_ch]  <= ctl_solo;
         if (ctl_pair) begin
            fader_q[ctl_mate] <= fader_in;
            mute_q[ctl_mate]  <= ctl_mute;
            solo_q[ctl_mate]  <= ctl_solo;
         end
      end
   end

   // send levels and pans per bus
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int b = 0; b < mmix_pkg::NBUS; b++) begin
            for (int i = 0; i < NCH; i++) begin
               send_lvl_q[b][i] <= mmix_pkg::SEND_RESET;
               send_pan_q[b][i] <= mmix_pkg::PAN_CENTER;
            end
         end
      end else if (do_link) begin
         for (int b = 0; b < mmix_pkg::NBUS; b++) begin
            send_lvl_q[b][1] <= send_lvl_q[b][0];
         end
      end else if (do_unlink) begin
         for (int b = 0; b < mmix_pkg::NBUS; b++) begin
            send_lvl_q[b][1] <= mmix_pkg::SEND_RESET;
            send_pan_q[b][1] <= mmix_pkg::PAN_CENTER;
            send_pan_q[b][0] <= mmix_pkg::PAN_CENTER;
         end
      end else if (copy_ok) begin
         for (int i = 0; i < NCH; i++) begin
            send_lvl_q[mix_copy_destination][i] <= fader_q[i];
            send_pan_q[mix_copy_destination][i] <= pan_q[i];
         end
      end else if (snd_wr && (snd_bus != 2'h3)) begin
         send_lvl_q[snd_bus][snd_ch] <= level_in;
         send_pan_q[snd_bus][snd_ch] <= span_in;
         if (snd_pair) begin
            send_lvl_q[snd_bus][snd_mate] <= level_in;
         end
      end
   end

   // sample unpack and fader stage
   logic signed [31:0] ch_s   [NCH];
   logic signed [31:0] ch_fad [NCH];
   logic [31:0]        lvl    [NCH];
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      assign ch_s[g]   = {{(32-SW){fifo_data[g*SW+SW-1]}}, fifo_data[g*SW +: SW]};
      assign ch_fad[g] = mulg(ch_s[g], fader_q[g]);
      wire signed [31:0] tap = meter_post ? ch_fad[g] : ch_s[g];
      assign lvl[g]    = tap[31] ? 32'(-tap) : 32'(tap);
   end

   // solo and mute gating of the monitor mix
   wire            any_solo = |solo_q;
   wire [NCH-1:0]  mon_on   = any_solo ? solo_q : ~mute_q;

   // bus accumulation over all channels
   logic signed [31:0] acc_mon_l, acc_mon_r;
   logic signed [31:0] acc_bus_l [mmix_pkg::NBUS];
   logic signed [31:0] acc_bus_r [mmix_pkg::NBUS];
   always_comb begin
      logic signed [31:0] src;
      logic signed [31:0] snd;
      logic [mmix_pkg::PW-1:0] sp;
      src = '0;
      snd = '0;
      sp  = mmix_pkg::PAN_CENTER;
      acc_mon_l = '0;
      acc_mon_r = '0;
      for (int b = 0; b < mmix_pkg::NBUS; b++) begin
         acc_bus_l[b] = '0;
         acc_bus_r[b] = '0;
      end
      for (int i = 0; i < NCH; i++) begin
         if (mon_on[i]) begin
            acc_mon_l = acc_mon_l + mulp(ch_fad[i], mmix_pkg::PAN_RIGHT - pan_q[i]);
            acc_mon_r = acc_mon_r + mulp(ch_fad[i], pan_q[i]);
         end
         for (int b = 0; b < mmix_pkg::NBUS; b++) begin
            if (b == int'(mmix_pkg::BUS_HP)) src = ch_s[i];
            else if (aux_pre[b]) src = ch_s[i];
            else src = mute_q[i] ? 32'sh0 : ch_fad[i];
            snd = mulg(src, send_lvl_q[b][i]);
            sp  = send_pan_q[b][i];
            if (linked_q && i == 0) sp = mmix_pkg::PAN_LEFT;
            if (linked_q && i == 1) sp = mmix_pkg::PAN_RIGHT;
            acc_bus_l[b] = acc_bus_l[b] + mulp(snd, mmix_pkg::PAN_RIGHT - sp);
            acc_bus_r[b] = acc_bus_r[b] + mulp(snd, sp);
         end
      end
   end

   // aux delay line, fed with saturated aux words
   logic [4*SW-1:0] aux_mem [mmix_pkg::AUX_DELAY];
   logic [4:0]      aux_wp_q;
   logic [5:0]      aux_fill_q;
   wire  [4*SW-1:0] aux_now = {sat(acc_bus_r[1]), sat(acc_bus_l[1]),
                               sat(acc_bus_r[0]), sat(acc_bus_l[0])};
   wire             aux_full = (aux_fill_q == mmix_pkg::AUX_DELAY_CNT);
   wire  [4*SW-1:0] aux_old  = aux_full ? aux_mem[aux_wp_q] : '0;

   always_ff @(posedge clock) begin
      if (pop) aux_mem[aux_wp_q] <= aux_now;
   end

   // delay line pointer and fill count
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aux_wp_q   <= '0;
         aux_fill_q <= '0;
      end else if (pop) begin
         aux_wp_q <= aux_wp_q + 1'b1;
         if (!aux_full) aux_fill_q <= aux_fill_q + 1'b1;
      end
   end

   // output registers, held until taken
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         out_valid_q <= 1'b0;
         mon_l  <= '0;
         mon_r  <= '0;
         aux1_l <= '0;
         aux1_r <= '0;
         aux2_l <= '0;
         aux2_r <= '0;
         headphone_cue_bus_l <= '0;
         headphone_cue_bus_r <= '0;
      end else if (pop) begin
         out_valid_q <= 1'b1;
         mon_l  <= sat(acc_mon_l);
         mon_r  <= sat(acc_mon_r);
         aux1_l <= aux_old[0*SW +: SW];
         aux1_r <= aux_old[1*SW +: SW];
         aux2_l <= rate_high ? '0 : aux_old[2*SW +: SW];
         aux2_r <= rate_high ? '0 : aux_old[3*SW +: SW];
         headphone_cue_bus_l <= sat(acc_bus_l[2]);
         headphone_cue_bus_r <= sat(acc_bus_r[2]);
      end else if (out_ready) begin
         out_valid_q <= 1'b0;
      end
   end
   assign out_valid = out_valid_q;

   // per channel peak hold and clip hold
   for (genvar g = 0; g < NCH; g++) begin : g_met
      logic [SW-1:0]               peak_q;
      logic [mmix_pkg::HOLD_W-1:0] pcnt_q;
      logic [mmix_pkg::HOLD_W-1:0] ccnt_q;
      logic                        clip_q;
      wire  [SW-1:0] cur  = (lvl[g] > 32'(mmix_pkg::FS_MAX)) ?
                            mmix_pkg::FS_MAX[SW-1:0] : lvl[g][SW-1:0];
      wire           over = lvl[g] > 32'(mmix_pkg::FS_MAX);
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            peak_q <= '0;
            pcnt_q <= '0;
            ccnt_q <= '0;
            clip_q <= 1'b0;
         end else if (pop) begin
            if (cur >= peak_q) begin
               peak_q <= cur;
               pcnt_q <= peak_hold_frames;
            end else if (pcnt_q == '0) begin
               peak_q <= cur;
            end else begin
               pcnt_q <= pcnt_q - 1'b1;
            end
            if (over) begin
               clip_q <= 1'b1;
               ccnt_q <= clip_hold_frames;
            end else if (ccnt_q == '0) begin
               clip_q <= 1'b0;
            end else begin
               ccnt_q <= ccnt_q - 1'b1;
            end
         end
      end
      assign meter_peak[g*SW +: SW] = peak_q;
      assign clip[g] = clip_q;
   end

   // checks
   fader_cap_a : assert property (@(posedge clock) disable iff (!rst_n)
      ctl_wr && !do_link && !do_unlink |=> fader_q[$past(ctl_ch)] <= mmix_pkg::GAIN_MAX)
      else $error("fader above ceiling");
   link_refuse_a : assert property (@(posedge clock) disable iff (!rst_n)
      link_req && link_set && !linked_q && !link_ok |=> !linked_q)
      else $error("link accepted on mismatched jacks");
   link_copy_a : assert property (@(posedge clock) disable iff (!rst_n)
      do_link |=> linked_q && fader_q[1] == $past(fader_q[0])
                  && pan_q[0] == mmix_pkg::PAN_LEFT && pan_q[1] == mmix_pkg::PAN_RIGHT)
      else $error("link did not copy settings");
   unlink_reset_a : assert property (@(posedge clock) disable iff (!rst_n)
      do_unlink |=> !linked_q && pan_q[0] == mmix_pkg::PAN_CENTER
                    && fader_q[1] == mmix_pkg::GAIN_UNITY && fader_q[0] == $past(fader_q[0]))
      else $error("unlink left wrong state");
   pair_mirror_a : assert property (@(posedge clock) disable iff (!rst_n)
      ctl_wr && ctl_pair && !do_unlink |=> fader_q[0] == fader_q[1] && mute_q[0] == mute_q[1])
      else $error("linked pair diverged");
   copy_mix_a : assert property (@(posedge clock) disable iff (!rst_n)
      copy_ok && !do_link && !do_unlink |=>
      send_lvl_q[$past(mix_copy_destination)][2] == $past(fader_q[2]))
      else $error("copy mix missed a fader");
   aux2_off_a : assert property (@(posedge clock) disable iff (!rst_n)
      pop && rate_high |=> out_valid && aux2_l == '0 && aux2_r == '0)
      else $error("second aux active at high rate");
   clip_set_a : assert property (@(posedge clock) disable iff (!rst_n)
      pop && lvl[0] > 32'(mmix_pkg::FS_MAX) |=> clip[0] ##1 (clip[0] || $past(pop)))
      else $error("clip not flagged");
   out_hold_a : assert property (@(posedge clock) disable iff (!rst_n)
      out_valid && !out_ready |=> out_valid && $stable(mon_l) && $stable(aux1_l))
      else $error("output dropped before taken");
endmodule // mmix_core

// ==== test/mmix_far_end.sv ====
`timescale 1ns/1ps
// far side: converter frame source and output sink
module mmix_far_end (
   // clock
   input  wire logic                              clock,
   // bench requests
   input  wire logic                              go,
   input  wire logic [mmix_pkg::FRAME_W-1:0]      frame,
   input  wire logic                              stall,
   // design side
   output logic                                   in_valid,
   input  wire logic                              in_ready,
   output logic [mmix_pkg::FRAME_W-1:0]           in_frame,
   output logic                                   out_ready
);
   // hold a frame until taken, then scramble the idle bus
   initial begin
      in_valid = 1'b0;
      in_frame = '0;
      forever begin
         @(posedge clock);
         if (in_valid && in_ready) begin
            in_valid <= 1'b0;
            in_frame <= ~in_frame;
         end else if (go) begin
            in_valid <= 1'b1;
            in_frame <= frame;
         end
      end
   end
   // sink takes every frame unless stalled
   assign out_ready = ~stall;
endmodule // mmix_far_end

// ==== test/tb.sv ====
`timescale 1ns/1ps
// mixer core bench
module tb;
   localparam logic [71:0] REST = {3{24'h7FFFFF}};
   logic        clock, rst_n, go, stall, in_valid, in_ready, out_valid, out_ready, linked;
   logic        ctl_wr, ctl_mute, ctl_solo, snd_wr, mix_copy_req, link_req, link_set;
   logic        rate_high, meter_post;
   logic [1:0]  ctl_ch, snd_bus, snd_ch, mix_copy_destination, aux_pre;
   logic [7:0]  jack_type;
   logic [15:0] ctl_fader, snd_level, hold;
   logic [8:0]  ctl_pan, snd_pan;
   logic [3:0]  clip;
   logic [23:0] mon_l, mon_r, aux1_l, aux1_r, aux2_l, aux2_r, cue_l, cue_r;
   logic [95:0] frame, in_frame, meter_peak;
   int          errors, n_tests, k;
   mmix_core mmix_core_inst (.clock(clock), .rst_n(rst_n), .in_valid(in_valid),
      .in_ready(in_ready), .in_frame(in_frame), .ctl_wr(ctl_wr), .ctl_ch(ctl_ch),
      .ctl_fader(ctl_fader), .ctl_pan(ctl_pan), .ctl_mute(ctl_mute), .ctl_solo(ctl_solo),
      .snd_wr(snd_wr), .snd_bus(snd_bus), .snd_ch(snd_ch), .snd_level(snd_level),
      .snd_pan(snd_pan), .mix_copy_req(mix_copy_req),
      .mix_copy_destination(mix_copy_destination), .link_req(link_req),
      .link_set(link_set), .jack_type(jack_type), .linked(linked), .aux_pre(aux_pre),
      .rate_high(rate_high), .meter_post(meter_post), .peak_hold_frames(hold),
      .clip_hold_frames(hold), .out_valid(out_valid), .out_ready(out_ready),
      .mon_l(mon_l), .mon_r(mon_r), .aux1_l(aux1_l), .aux1_r(aux1_r), .aux2_l(aux2_l),
      .aux2_r(aux2_r), .headphone_cue_bus_l(cue_l), .headphone_cue_bus_r(cue_r),
      .meter_peak(meter_peak), .clip(clip));
   mmix_far_end mmix_far_end_inst (.clock(clock), .go(go), .frame(frame), .stall(stall),
      .in_valid(in_valid), .in_ready(in_ready), .in_frame(in_frame), .out_ready(out_ready));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic ctl(input logic [1:0] c, input logic [15:0] f, input logic [8:0] p,
                      input logic m, input logic s);
      {ctl_ch, ctl_fader, ctl_pan, ctl_mute, ctl_solo, ctl_wr} = {c, f, p, m, s, 1'b1};
      tick(1);
      ctl_wr = 1'b0;
   endtask
   task automatic snd(input logic [1:0] b, input logic [15:0] l, input logic [8:0] p);
      {snd_bus, snd_ch, snd_level, snd_pan, snd_wr} = {b, 2'h0, l, p, 1'b1};
      tick(1);
      snd_wr = 1'b0;
   endtask
   task automatic link(input logic s);
      {link_set, link_req} = {s, 1'b1};
      tick(1);
      link_req = 1'b0;
      tick(1);
   endtask
   // bounded wait for a standing output frame
   task automatic wait_out;
      for (int i = 0; i < 50 && out_valid !== 1'b1; i++) tick(1);
      if (out_valid !== 1'b1) begin
         errors++;
         tally_and_finish();
      end
   endtask
   task automatic take;
      stall = 1'b0;
      tick(1);
      stall = 1'b1;
   endtask
   // release the standing frame, offer a new one, wait for its result
   task automatic mix(input logic [95:0] f);
      if (out_valid) take();
      {frame, go} = {f, 1'b1};
      tick(1);
      go = 1'b0;
      wait_out();
   endtask
   task automatic do_reset;
      rst_n = 1'b0;
      tick(10);
      rst_n = 1'b1;
   endtask
   initial begin
      {go, ctl_wr, snd_wr, mix_copy_req, link_req, link_set, rate_high, meter_post} = '0;
      {ctl_ch, snd_bus, snd_ch, mix_copy_destination, jack_type, ctl_mute, ctl_solo} = '0;
      {ctl_fader, snd_level, ctl_pan, snd_pan, frame, errors, n_tests, stall} = '0;
      aux_pre = 2'h0;
      stall = 1'b1;
      hold = 16'h0004;
      do_reset();
      chk({in_ready, out_valid, linked, clip}, 7'h40);
      for (int c = 1; c < 4; c++) ctl(2'(c), 16'h0000, 9'h000, 1'b0, 1'b0);
      ctl(2'h0, 16'h1000, 9'h000, 1'b0, 1'b0);
      mix({REST, 24'h123456});
      chk({mon_l, mon_r}, {24'h123456, 24'h000000});
      meter_post = 1'b1;
      ctl(2'h0, 16'hFFFF, 9'h000, 1'b0, 1'b0);
      mix({REST, 24'h010000});
      chk(mon_l, 24'h03FB20);
      chk(meter_peak[23:0], 24'h123456);
      hold = 16'h0000;
      mix({REST, 24'h7FFFFF});
      chk(mon_l, 24'h7FFFFF);
      chk(clip[0], 1'b1);
      $display("gain tests done");
      snd(mmix_pkg::BUS_HP, 16'h1000, 9'h000);
      ctl(2'h0, 16'h1000, 9'h000, 1'b1, 1'b0);
      mix({REST, 24'h123456});
      chk({mon_l, cue_l}, {24'h000000, 24'h123456});
      chk(meter_peak[23:0], 24'h123456);
      chk(clip[0], 1'b0);
      ctl(2'h0, 16'h0000, 9'h000, 1'b0, 1'b0);
      mix({REST, 24'h123456});
      chk({mon_l, cue_l}, {24'h000000, 24'h123456});
      ctl(2'h0, 16'h1000, 9'h000, 1'b1, 1'b1);
      ctl(2'h1, 16'h1000, 9'h000, 1'b0, 1'b0);
      mix({48'h0, 24'h010000, 24'h100000});
      chk(mon_l, 24'h100000);
      $display("mute and solo tests done");
      ctl(2'h1, 16'h0000, 9'h000, 1'b0, 1'b0);
      ctl(2'h0, 16'h0800, 9'h000, 1'b0, 1'b0);
      {mix_copy_destination, mix_copy_req} = {mmix_pkg::BUS_HP, 1'b1};
      tick(1);
      mix_copy_req = 1'b0;
      mix({REST, 24'h100000});
      chk({cue_l, cue_r}, {24'h080000, 24'h000000});
      $display("copy mix test done");
      for (int t = 0; t < 3; t++) begin
         jack_type = (t == 0) ? 8'h0A : (t == 1) ? 8'h04 : 8'h00;
         link(1'b1);
         chk(linked, t == 2);
      end
      mix({48'h0, 24'h100000, 24'h000000});
      chk({mon_l, mon_r}, {24'h000000, 24'h080000});
      chk({cue_l, cue_r}, {24'h000000, 24'h080000});
      ctl(2'h1, 16'h1000, 9'h100, 1'b0, 1'b0);
      mix({48'h0, 24'h000000, 24'h100000});
      chk({mon_l, mon_r}, {24'h100000, 24'h000000});
      link(1'b0);
      mix({48'h0, 24'h200000, 24'h100000});
      chk({linked, mon_l, mon_r}, {1'b0, 24'h180000, 24'h180000});
      $display("link tests done");
      do_reset();
      snd(mmix_pkg::BUS_AUX1, 16'h1000, 9'h000);
      snd(mmix_pkg::BUS_AUX2, 16'h1000, 9'h000);
      ctl(2'h0, 16'h0800, 9'h080, 1'b0, 1'b0);
      aux_pre = 2'h2;
      for (int i = 0; i < 40; i++) begin
         rate_high = (i >= 36);
         mix({72'h0, 24'(i + 1) << 12});
         chk({aux1_r, aux1_l}, (i < 32) ? 0 : (i - 31) << 11);
         chk({aux2_r, aux2_l}, (i < 32 || i > 35) ? 0 : (i - 31) << 12);
      end
      $display("aux tests done");
      ctl(2'h0, 16'h1000, 9'h080, 1'b0, 1'b0);
      take();
      for (k = 0; k < 12 && in_ready === 1'b1; k++) begin
         {frame, go} = {72'h0, 24'(k + 1) << 13, 1'b1};
         tick(1);
         go = 1'b0;
         tick(1);
      end
      chk(k, mmix_pkg::FIFO_DEPTH + 1);
      for (int j = 0; j < k; j++) begin
         wait_out();
         chk(mon_l, (j + 1) << 12);
         take();
      end
      tick(2);
      chk(out_valid, 1'b0);
      $display("buffer test done");
      tally_and_finish();
   end
endmodule // tb
